// *** rtl/mem_decode_pkg.sv ***
// Constants, register map and carrier types for the bridge memory decoder.
// Assumes an APB master with 32-bit data; registers sit one per aligned word.
// How it works
// - An 8-bit main memory top register maps to PCI address bits 28 to 21, 2 MByte steps to 512 MByte.
// - Main memory select asserts from 2 MByte up to and including the top boundary, except inside the main hole.
// - Top value ffh reaches 512 MByte minus one and value 00h disables the region above 2 MByte.
// - Forward control bits 7 to 4 give an ISA top of memory of n plus one MByte.
// - ISA or DMA cycles from 1 MByte up to the ISA top of memory go to PCI unless inside the ISA hole.
// - Forward control bits 0 to 3 enable the 0-512K, 512-640K, 640-768K and 896-960K blocks.
// - When the lower firmware enable (utility select A bit 6) is set, 896-960K stays on ISA.
// - Each ROM block enable bit forwards one 16 KByte block from 768K up to 896K.
// - A clear ROM block enable bit keeps that block on ISA.
// - ISA addresses from 1 MByte up that lie from hole bottom to hole top, compared on bits 23 to 16, are not forwarded.
// - The hole is placed in 64 KByte units and its top value includes its whole block.
// - Only addresses with bits 31 to 24 all zero can fall in the ISA hole.
// - A hole top below hole bottom disables the hole; reset values 10h and 0fh do so.
// - The main hole bounded by the main hole bottom and top registers suppresses main memory select.
// - With the master enable (bit 4 of the main control register) clear, main select never asserts.
package mem_decode_pkg;
   localparam logic [7:0] ADDR_MAIN_CONTROL   = 8'h44;
   localparam logic [7:0] ADDR_MAIN_HOLE_BOT  = 8'h45;
   localparam logic [7:0] ADDR_MAIN_HOLE_TOP  = 8'h46;
   localparam logic [7:0] ADDR_MAIN_TOP       = 8'h47;
   localparam logic [7:0] ADDR_ISA_FWD_CTRL   = 8'h48;
   localparam logic [7:0] ADDR_ISA_ROM_EN     = 8'h49;
   localparam logic [7:0] ADDR_ISA_HOLE_BOT   = 8'h4a;
   localparam logic [7:0] ADDR_ISA_HOLE_TOP   = 8'h4b;
   localparam logic [7:0] ADDR_UTIL_SEL_A     = 8'h4e;

   localparam logic [7:0] RST_MAIN_CONTROL    = 8'h00;
   localparam logic [7:0] RST_MAIN_HOLE_BOT   = 8'h10;
   localparam logic [7:0] RST_MAIN_HOLE_TOP   = 8'h0f;
   localparam logic [7:0] RST_MAIN_TOP        = 8'h00;
   localparam logic [7:0] RST_ISA_FWD_CTRL    = 8'h01;
   localparam logic [7:0] RST_ISA_ROM_EN      = 8'h00;
   localparam logic [7:0] RST_ISA_HOLE_BOT    = 8'h10;
   localparam logic [7:0] RST_ISA_HOLE_TOP    = 8'h0f;
   localparam logic [7:0] RST_UTIL_SEL_A      = 8'h07;

   localparam logic [7:0] MASK_MAIN_CONTROL   = 8'h1f;

   localparam int MAIN_MASTER_EN_BIT = 4;
   localparam int LOWER_FW_EN_BIT    = 6;
   localparam int ISA_TOP_LSB        = 4;
   localparam int BLK_LOW512         = 0;
   localparam int BLK_512_640        = 1;
   localparam int BLK_VIDEO          = 2;
   localparam int BLK_LOW_FW         = 3;

   // Address boundaries in bytes for the blocks below 1 MByte and the 2 MByte start of main memory.
   localparam logic [31:0] KB512   = 32'h0008_0000;
   localparam logic [31:0] KB640   = 32'h000a_0000;
   localparam logic [31:0] KB768   = 32'h000c_0000;
   localparam logic [31:0] KB896   = 32'h000e_0000;
   localparam logic [31:0] KB960   = 32'h000f_0000;
   localparam logic [31:0] MB1     = 32'h0010_0000;
   localparam logic [31:0] MB2     = 32'h0020_0000;

   typedef struct packed {
      logic [7:0] main_control;
      logic [7:0] main_hole_bottom;
      logic [7:0] main_hole_top;
      logic [7:0] main_memory_top;
      logic [7:0] isa_forward_control;
      logic [7:0] isa_rom_block_enable;
      logic [7:0] isa_hole_bottom;
      logic [7:0] isa_hole_top;
      logic [7:0] utility_chip_select_a;
   } cfg_s;
endpackage

// *** rtl/mem_decode.sv ***
// Memory address decoder of the bridge: main memory select and ISA forwarding.
// Assumes an APB master on mclk_in; the address inputs are same-clock qualified.
`timescale 1ns/1ps
`default_nettype none
module mem_decode (
   input  wire logic        mclk_in,
   input  wire logic        rst_n_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   input  wire logic [3:0]  pstrb_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic [31:0] pci_addr_in,
   input  wire logic        pci_valid_in,
   input  wire logic [31:0] isa_addr_in,
   input  wire logic        isa_valid_in,
   output logic             main_memory_select_out,
   output logic             isa_to_pci_out
);
   mem_decode_pkg::cfg_s cfg;
   logic [31:0]          rdata;
   logic                 sel_main;
   logic                 fwd_isa;

   wire        acc        = psel_in & penable_in;
   wire        wr         = acc & pwrite_in & pstrb_in[0];

   // The address is passed in so that every decode follows a change of paddr_in.
   function automatic logic hit(input logic [11:0] pa, input logic [7:0] a);
      hit = (pa[1:0] == 2'b00) && (pa[11:10] == 2'b00) && (pa[9:2] == a);
   endfunction

   wire h_mc  = hit(paddr_in, mem_decode_pkg::ADDR_MAIN_CONTROL);
   wire h_mhb = hit(paddr_in, mem_decode_pkg::ADDR_MAIN_HOLE_BOT);
   wire h_mht = hit(paddr_in, mem_decode_pkg::ADDR_MAIN_HOLE_TOP);
   wire h_mt  = hit(paddr_in, mem_decode_pkg::ADDR_MAIN_TOP);
   wire h_fc  = hit(paddr_in, mem_decode_pkg::ADDR_ISA_FWD_CTRL);
   wire h_rb  = hit(paddr_in, mem_decode_pkg::ADDR_ISA_ROM_EN);
   wire h_ihb = hit(paddr_in, mem_decode_pkg::ADDR_ISA_HOLE_BOT);
   wire h_iht = hit(paddr_in, mem_decode_pkg::ADDR_ISA_HOLE_TOP);
   wire h_us  = hit(paddr_in, mem_decode_pkg::ADDR_UTIL_SEL_A);
   wire mapped = h_mc | h_mhb | h_mht | h_mt | h_fc | h_rb | h_ihb | h_iht | h_us;

   // Zero-wait slave; unmapped offsets answer with an error and read zero.
   assign pready_out  = 1'b1;
   assign pslverr_out = acc & ~mapped;

   wire [7:0] rsel = h_mc  ? cfg.main_control :
                     h_mhb ? cfg.main_hole_bottom :
                     h_mht ? cfg.main_hole_top :
                     h_mt  ? cfg.main_memory_top :
                     h_fc  ? cfg.isa_forward_control :
                     h_rb  ? cfg.isa_rom_block_enable :
                     h_ihb ? cfg.isa_hole_bottom :
                     h_iht ? cfg.isa_hole_top :
                     h_us  ? cfg.utility_chip_select_a : 8'h00;
   assign rdata = {24'h00_0000, rsel};
   assign prdata_out = rdata;

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg.main_control          <= mem_decode_pkg::RST_MAIN_CONTROL;
         cfg.main_hole_bottom      <= mem_decode_pkg::RST_MAIN_HOLE_BOT;
         cfg.main_hole_top         <= mem_decode_pkg::RST_MAIN_HOLE_TOP;
         cfg.main_memory_top       <= mem_decode_pkg::RST_MAIN_TOP;
         cfg.isa_forward_control   <= mem_decode_pkg::RST_ISA_FWD_CTRL;
         cfg.isa_rom_block_enable  <= mem_decode_pkg::RST_ISA_ROM_EN;
         cfg.isa_hole_bottom       <= mem_decode_pkg::RST_ISA_HOLE_BOT;
         cfg.isa_hole_top          <= mem_decode_pkg::RST_ISA_HOLE_TOP;
         cfg.utility_chip_select_a <= mem_decode_pkg::RST_UTIL_SEL_A;
      end else if (wr) begin
         if (h_mc) begin
            cfg.main_control <= pwdata_in[7:0] & mem_decode_pkg::MASK_MAIN_CONTROL;
         end
         if (h_mhb) begin
            cfg.main_hole_bottom <= pwdata_in[7:0];
         end
         if (h_mht) begin
            cfg.main_hole_top <= pwdata_in[7:0];
         end
         if (h_mt) begin
            cfg.main_memory_top <= pwdata_in[7:0];
         end
         if (h_fc) begin
            cfg.isa_forward_control <= pwdata_in[7:0];
         end
         if (h_rb) begin
            cfg.isa_rom_block_enable <= pwdata_in[7:0];
         end
         if (h_ihb) begin
            cfg.isa_hole_bottom <= pwdata_in[7:0];
         end
         if (h_iht) begin
            cfg.isa_hole_top <= pwdata_in[7:0];
         end
         if (h_us) begin
            cfg.utility_chip_select_a <= pwdata_in[7:0];
         end
      end
   end

   // Hole test shared by both decoders; top includes its whole 64K block.
   function automatic logic in_hole(input logic [31:0] a, input logic [7:0] bot,
                                    input logic [7:0] top);
      in_hole = (a[31:24] == 8'h00) && (top >= bot) && (a[23:16] >= bot) && (a[23:16] <= top);
   endfunction

   // Boundary at bits 28 to 21.
   // ffh reaches 512M-1; 00h covers nothing above 2M.
   wire main_top_hit = (pci_addr_in[31:29] == 3'b000) &&
                       (pci_addr_in[28:21] <= cfg.main_memory_top);
   wire main_range   = (pci_addr_in >= mem_decode_pkg::MB2) && main_top_hit;
   wire main_hole    = in_hole(pci_addr_in, cfg.main_hole_bottom, cfg.main_hole_top);
   wire main_en      = cfg.main_control[mem_decode_pkg::MAIN_MASTER_EN_BIT];
   assign sel_main   = pci_valid_in & main_en & main_range & ~main_hole;

   wire [3:0] fc_en  = cfg.isa_forward_control[3:0];
   wire [3:0] isa_tp = cfg.isa_forward_control[7:4];
   // Top is n plus one MByte.
   wire [4:0] isa_top_mb = {1'b0, isa_tp} + 5'd1;
   // 1 MByte up to ISA top.
   wire hi_range = (isa_addr_in[31:24] == 8'h00) && (isa_addr_in >= mem_decode_pkg::MB1) &&
                   ({1'b0, isa_addr_in[23:20]} < isa_top_mb);
   wire a_lo    = isa_addr_in < mem_decode_pkg::KB512;
   wire a_512   = (isa_addr_in >= mem_decode_pkg::KB512) && (isa_addr_in < mem_decode_pkg::KB640);
   wire a_vid   = (isa_addr_in >= mem_decode_pkg::KB640) && (isa_addr_in < mem_decode_pkg::KB768);
   wire a_rom   = (isa_addr_in >= mem_decode_pkg::KB768) && (isa_addr_in < mem_decode_pkg::KB896);
   wire a_fw    = (isa_addr_in >= mem_decode_pkg::KB896) && (isa_addr_in < mem_decode_pkg::KB960);
   wire fw_hold = cfg.utility_chip_select_a[mem_decode_pkg::LOWER_FW_EN_BIT];
   // Clear bit keeps block on ISA.
   wire rom_fwd = a_rom && cfg.isa_rom_block_enable[isa_addr_in[16:14]];
   wire low_fwd = (a_lo  & fc_en[mem_decode_pkg::BLK_LOW512]) |
                  (a_512 & fc_en[mem_decode_pkg::BLK_512_640]) |
                  (a_vid & fc_en[mem_decode_pkg::BLK_VIDEO]) |
                  (a_fw  & fc_en[mem_decode_pkg::BLK_LOW_FW] & ~fw_hold);
   // Hole compare on bits 23 to 16.
   wire isa_hole = in_hole(isa_addr_in, cfg.isa_hole_bottom, cfg.isa_hole_top);
   // Otherwise the cycle stays on ISA.
   assign fwd_isa = isa_valid_in & (low_fwd | rom_fwd | (hi_range & ~isa_hole));

   // Registered so both decisions are glitch-free one cycle after the address.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         main_memory_select_out <= 1'b0;
         isa_to_pci_out         <= 1'b0;
      end else begin
         main_memory_select_out <= sel_main;
         isa_to_pci_out         <= fwd_isa;
      end
   end
endmodule // mem_decode
`default_nettype wire

// *** testbench/mem_decode_asserts.sv ***
// Checker for the bridge memory decoder: bus timing and decode bounds.
// Assumes it is bound to mem_decode and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module mem_decode_asserts (
   input wire logic        mclk_in,
   input wire logic        rst_n_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   input wire logic        pci_valid_in,
   input wire logic        isa_valid_in,
   input wire logic        main_memory_select_out,
   input wire logic        isa_to_pci_out,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] pci_addr_in,
   input wire logic [31:0] isa_addr_in,
   input wire logic [3:0]  pstrb_in
);
   // Shadow of the master enable, rebuilt from writes seen on the bus.
   logic en;
   always_ff @(posedge mclk_in or negedge rst_n_in)
      if (!rst_n_in) en <= 1'b0;
      else if (psel_in && penable_in && pwrite_in && pstrb_in[0] && paddr_in == 12'h110)
         en <= pwdata_in[4];
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_setup; psel_in && !penable_in; endsequence
   sequence s_access; psel_in && penable_in; endsequence
   property p_zero_wait; s_setup ##1 s_access |-> pready_out; endproperty
   a_zero_wait: assert property (p_zero_wait) else $error("access without ready");
   property p_unmapped; s_access and paddr_in > 12'h138 |-> pslverr_out; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   property p_pci_idle; !pci_valid_in |=> !main_memory_select_out; endproperty
   a_pci_idle: assert property (p_pci_idle) else $error("select without request");
   property p_low; pci_valid_in && pci_addr_in < 32'h0020_0000 |=> !main_memory_select_out;
   endproperty
   a_low: assert property (p_low) else $error("select below 2 MByte");
   property p_high; pci_valid_in && pci_addr_in[31:29] != 3'b000 |=> !main_memory_select_out;
   endproperty
   a_high: assert property (p_high) else $error("select above 512 MByte");
   property p_master_off; !en |=> !main_memory_select_out; endproperty
   a_master_off: assert property (p_master_off) else $error("select while disabled");
   property p_isa_idle; !isa_valid_in |=> !isa_to_pci_out; endproperty
   a_isa_idle: assert property (p_isa_idle) else $error("forward without cycle");
   property p_isa_high; isa_valid_in && isa_addr_in[31:24] != 8'h00 |=> !isa_to_pci_out;
   endproperty
   a_isa_high: assert property (p_isa_high) else $error("forward above 16 MByte");
   property p_isa_gap; isa_valid_in && isa_addr_in[31:16] == 16'h000f |=> !isa_to_pci_out;
   endproperty
   a_isa_gap: assert property (p_isa_gap) else $error("forward of top block");
endmodule // mem_decode_asserts
bind mem_decode mem_decode_asserts u_mem_decode_asserts (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
   .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .pci_valid_in(pci_valid_in), .isa_valid_in(isa_valid_in),
   .main_memory_select_out(main_memory_select_out), .isa_to_pci_out(isa_to_pci_out),
   .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pci_addr_in(pci_addr_in),
   .isa_addr_in(isa_addr_in), .pstrb_in(pstrb_in));
`default_nettype wire

// *** testbench/addr_source_model.sv ***
// Far-side model: one master presenting an address on both buses.
// Assumes the bench holds the request address when it goes idle.
`timescale 1ns/1ps
`default_nettype none
module addr_source_model (
   input  wire logic [31:0] req_addr_in,
   input  wire logic        req_valid_in,
   output logic      [31:0] bus_addr_out,
   output logic             bus_valid_out
);
   // Idle lines show the inverse of the last address, so no stale value can pass.
   assign bus_addr_out  = req_valid_in ? req_addr_in : ~req_addr_in;
   assign bus_valid_out = req_valid_in;
endmodule // addr_source_model
`default_nettype wire

// *** testbench/isa_pci_memory_decoder_tb.sv ***
// Testbench for mem_decode: register access and both address decoders.
// Assumes the model feeds one address to the PCI and ISA inputs alike.
`timescale 1ns/1ps
`default_nettype none
module isa_pci_memory_decoder_tb;
   logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, go = 0, rv = 0;
   logic        bv, sel, fwd, rdy, err, se;
   logic [11:0] pa = '0;
   logic [31:0] pwd = '0, ra = '0, ba, rdat, rd_d;
   logic [7:0]  cfg [9] = '{8'h00, 8'h10, 8'h0f, 8'h00, 8'h01, 8'h00, 8'h10, 8'h0f, 8'h07};
   logic [1:0]  q [$];
   int          n_errors = 0, num_checks = 0;
   mem_decode u_mem_decode (.mclk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .pstrb_in(4'h1), .prdata_out(rdat),
      .pready_out(rdy), .pslverr_out(err), .pci_addr_in(ba), .pci_valid_in(bv),
      .isa_addr_in(ba), .isa_valid_in(bv), .main_memory_select_out(sel), .isa_to_pci_out(fwd));
   addr_source_model u_addr_source_model (.req_addr_in(ra), .req_valid_in(rv),
      .bus_addr_out(ba), .bus_valid_out(bv));
   initial forever #20 clk = ~clk;
   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
      num_checks++;
      if (s !== e) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   function automatic logic [7:0] ix(int i);
      return (i == 8) ? 8'h4e : 8'h44 + 8'(i);
   endfunction
   function automatic logic hole(logic [31:0] a, logic [7:0] b, logic [7:0] t);
      return a[31:24] == 8'h00 && a[23:16] >= b && a[23:16] <= t;
   endfunction
   function automatic logic [1:0] expect_of(logic [31:0] a, logic v);
      logic m, f;
      logic [5:0] k;
      k = a[19:14];
      m = cfg[0][4] && cfg[3] != 8'h00 && a >= 32'h0020_0000 && a[31:29] == 3'b000
          && a[28:21] <= cfg[3] && !hole(a, cfg[1], cfg[2]);
      if (a[31:20] != 12'h000) f = a[31:24] == 8'h00 && a[23:20] <= cfg[4][7:4];
      else f = k < 32 ? cfg[4][0] : k < 40 ? cfg[4][1] : k < 48 ? cfg[4][2] :
               k < 56 ? cfg[5][k[2:0]] : k < 60 ? cfg[4][3] && !cfg[8][6] : 1'b0;
      return {m && v, f && v && !hole(a, cfg[6], cfg[7])};
   endfunction
   task automatic apb(logic w, logic [7:0] i, logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1; pen <= 0; pwr <= w; pa <= {2'b00, i, 2'b00}; pwd <= d;
      @(posedge clk);
      pen <= 1;
      n = 0;
      do begin @(posedge clk); n++; end while (!rdy && n < 50);
      if (!rdy) begin n_errors++; final_report(); end
      rd_d = rdat;
      se = err;
      psel <= 0; pen <= 0;
   endtask
   task automatic wreg(int i, logic [7:0] v);
      apb(1, ix(i), {24'h0, v});
      cfg[i] = (i == 0) ? v & 8'h1f : v;
      apb(0, ix(i), 0);
      chk("register", cfg[i], rd_d[7:0]);
      chk("read upper", 8'h00, rd_d[31:24] | rd_d[23:16] | rd_d[15:8]);
      chk("error flag", 8'h00, {7'h00, se});
   endtask
   task automatic dec(logic [31:0] a, logic v);
      @(posedge clk);
      ra <= a; rv <= v; go <= 1;
      q.push_back(expect_of(a, v));
   endtask
   initial forever begin
      @(posedge clk);
      if (go) begin
         @(negedge clk);
         chk("select", {7'h0, q[0][1]}, {7'h0, sel});
         chk("forward", {7'h0, q[0][0]}, {7'h0, fwd});
         void'(q.pop_front());
      end
   end
   initial begin
      logic [7:0] v;
      logic [31:0] a;
      void'($urandom(22));
      repeat (6) @(posedge clk);
      rst_n <= 1;
      for (int i = 0; i < 9; i++) begin
         apb(0, ix(i), 0);
         chk("reset value", cfg[i], rd_d[7:0]);
      end
      apb(0, 8'h50, 0);
      chk("unmapped", 8'h80, {se, rd_d[6:0]});
      for (int r = 0; r < 14; r++) begin
         for (int i = 0; i < 9; i++) begin
            v = 8'($urandom);
            // holes at or above 1 MByte
            if ((i % 5) inside {1, 2} && v < 8'h10) v = v | 8'h10;
            if (i == 3 && r < 2) v = r ? 8'hff : 8'h00;
            wreg(i, v);
         end
         for (int j = 0; j < 40; j++) begin
            case (j % 5)
               0: a = {cfg[6 - 5 * (j / 20)], 16'h0} - 32'(j & 1);
               1: a = {cfg[7 - 5 * (j / 20)], 16'hffff} + 32'(j & 1);
               2: a = {3'b000, cfg[3], 21'h1fffff} + 32'(j & 1);
               3: a = {7'h00, 5'(cfg[4][7:4]) + 5'h01, 20'h0} - 32'(j & 1);
               default: a = $urandom >> $urandom_range(4, 12);
            endcase
            dec(a, $urandom_range(0, 7) != 0);
         end
         @(posedge clk);
         go <= 0; rv <= 0;
      end
      repeat (2) @(posedge clk);
      final_report();
   end
endmodule // isa_pci_memory_decoder_tb
`default_nettype wire
